//--- include/lds_pkg.sv
// constants, register map and state codes for the led sequencer/fault block
// assumes a single 125 mhz device clock; all times are turned into cycle counts here
package lds_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_MHZ        = 125;
	localparam int DETECT_US      = 256;
	localparam int DETECT_CYC     = DETECT_US * CLK_MHZ;
	localparam int SOFTSTART_MS   = 128;
	localparam int SOFTSTART_CYC  = SOFTSTART_MS * 1000 * CLK_MHZ;
	localparam int BLANK_MS       = 32;
	localparam int BLANK_CYC      = BLANK_MS * 1000 * CLK_MHZ;
	localparam int SHDN_MS        = 32;
	localparam int SHDN_CYC       = SHDN_MS * 1000 * CLK_MHZ;
	localparam int EDGE_BLANK_US  = 4;
	localparam int EDGE_BLANK_CYC = EDGE_BLANK_US * CLK_MHZ;
	localparam int OPEN_US        = 20;
	localparam int OPEN_CYC       = OPEN_US * CLK_MHZ;
	localparam int SHORT_US       = 2;
	localparam int SHORT_CYC      = SHORT_US * CLK_MHZ;

	// ==========================================================
	// widths
	localparam int CNT_W  = 25;
	localparam int FT_W   = 12;
	localparam int ADDR_W = 12;
	localparam int CH_N   = 4;

	// ==========================================================
	// register map
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] CTRL_ADDR   = 12'h004;
	localparam logic [CH_N-1:0]   CTRL_RESET  = 4'h0;
	localparam int CTRL_MASK_POS   = 0;
	localparam int STAT_STATE_POS  = 0;
	localparam int STAT_USED_POS   = 8;
	localparam int STAT_OPEN_POS   = 12;
	localparam int STAT_SHORT_POS  = 13;
	localparam int STAT_THERM_POS  = 14;
	localparam int STAT_LOCK_POS   = 15;

	// ==========================================================
	// sequencer states
	typedef enum logic [4:0] {
		ST_OFF    = 5'h01,
		ST_DETECT = 5'h02,
		ST_SOFT   = 5'h04,
		ST_BLANK  = 5'h08,
		ST_RUN    = 5'h10
	} lds_state_t;

endpackage

//--- src/lds_low_timer.sv
// counts continuous cycles of a condition and flags when a limit is reached
// assumes the caller clears it on lockout; count saturates at the limit
`timescale 1ns/1ps
module lds_low_timer (
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic                       clear_in,
	input  wire logic                       cond_in,
	input  wire logic [lds_pkg::CNT_W-1:0]  limit_in,
	output logic                            done_out
);
	logic [lds_pkg::CNT_W-1:0] cnt_reg;

	// ==========================================================
	// continuous-condition counter
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= 25'h0;
		end else if (clear_in || !cond_in) begin
			cnt_reg <= 25'h0;
		end else if (cnt_reg != limit_in) begin
			cnt_reg <= cnt_reg + 25'h1;
		end
	end

	assign done_out = cond_in && (cnt_reg == limit_in);
endmodule

//--- src/lds_fault_timer.sv
// accumulation timer for one fault condition
// counts only while armed, holds while disarmed, drops to zero when the condition goes away
`timescale 1ns/1ps
module lds_fault_timer #(
	parameter int LIMIT = 2
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic clear_in,
	input  wire logic cond_in,
	input  wire logic arm_in,
	output logic      trip_out
);
	localparam logic [lds_pkg::FT_W-1:0] LAST = lds_pkg::FT_W'(LIMIT - 1);
	logic [lds_pkg::FT_W-1:0] cnt_reg;

	// ==========================================================
	// accumulator
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= 12'h0;
		end else if (clear_in || !cond_in) begin
			cnt_reg <= 12'h0;
		end else if (arm_in && cnt_reg != LAST) begin
			cnt_reg <= cnt_reg + 12'h1;
		end
	end

	assign trip_out = arm_in && cond_in && (cnt_reg == LAST);
endmodule

//--- src/lds_ctrl.sv
// sequencing and protection controller of a four-channel led current-sink driver
// assumes comparator outputs arrive synchronous to CLOCK_IN; registers reached over apb
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module lds_ctrl #(
	parameter logic [24:0] DETECT_CYC    = 25'(lds_pkg::DETECT_CYC),
	parameter logic [24:0] SOFTSTART_CYC = 25'(lds_pkg::SOFTSTART_CYC),
	parameter logic [24:0] BLANK_CYC     = 25'(lds_pkg::BLANK_CYC),
	parameter logic [24:0] SHDN_CYC      = 25'(lds_pkg::SHDN_CYC)
) (
	input  wire logic        CLOCK_IN,
	input  wire logic        RST_N_IN,
	input  wire logic        EN_PWM_IN,
	input  wire logic        SUPPLY_LOW_IN,
	input  wire logic        OVER_TEMP_IN,
	input  wire logic [3:0]  CH_FLOAT_IN,
	input  wire logic [3:0]  CH_OPEN_SENSE_IN,
	input  wire logic        SHORT_SENSE_IN,
	input  wire logic        PSEL_IN,
	input  wire logic        PENABLE_IN,
	input  wire logic        PWRITE_IN,
	input  wire logic [11:0] PADDR_IN,
	input  wire logic [31:0] PWDATA_IN,
	output logic      [31:0] PRDATA_OUT,
	output logic             PREADY_OUT,
	output logic             PSLVERR_OUT,
	output logic      [3:0]  CHANNEL_GATE_DRIVE_OUT,
	output logic             CONVERTER_FEEDBACK_FORCE_OUT,
	output logic             HEADROOM_FEEDBACK_CONTROL_OUT,
	output logic             FAULT_N_OUT
);
	lds_pkg::lds_state_t state_reg;
	logic [24:0] phase_cnt_reg;
	logic [3:0]  used_reg;
	logic [3:0]  mask_reg;
	logic        open_latch_reg;
	logic        short_latch_reg;
	logic        en_prev_reg;
	logic [9:0]  eb_cnt_reg;
	logic        eb_done_reg;
	logic        low_done;
	logic        prot_on;
	logic        fault_arm;
	logic        open_cond;
	logic        open_trip;
	logic        short_trip;
	logic        seq_clear;
	logic        apb_access;
	logic        apb_take;
	logic        addr_ok;
	logic [31:0] status_word;
	logic [3:0]  gate_next;

	localparam logic [9:0] EB_LAST = 10'(lds_pkg::EDGE_BLANK_CYC - 1);

	// ==========================================================
	// shutdown detection
	// enable low for the full delay, or supply low, returns everything to idle
	lds_low_timer u_shdn (
		.clk_in   (CLOCK_IN),
		.rst_n_in (RST_N_IN),
		.clear_in (SUPPLY_LOW_IN),
		.cond_in  (!EN_PWM_IN),
		.limit_in (SHDN_CYC - 25'h1),
		.done_out (low_done)
	);

	assign seq_clear = SUPPLY_LOW_IN || low_done;

	// ==========================================================
	// sequencer
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			state_reg     <= lds_pkg::ST_OFF;
			phase_cnt_reg <= 25'h0;
		end else if (SUPPLY_LOW_IN) begin
			state_reg     <= lds_pkg::ST_OFF;
			phase_cnt_reg <= 25'h0;
		end else if (low_done) begin
			state_reg     <= lds_pkg::ST_OFF;
			phase_cnt_reg <= 25'h0;
		end else begin
			case (state_reg)
				lds_pkg::ST_OFF: begin
					phase_cnt_reg <= 25'h0;
					if (EN_PWM_IN) begin
						state_reg <= lds_pkg::ST_DETECT;
					end
				end
				lds_pkg::ST_DETECT: begin
					if (phase_cnt_reg == DETECT_CYC - 25'h1) begin
						state_reg     <= lds_pkg::ST_SOFT;
						phase_cnt_reg <= 25'h0;
					end else begin
						phase_cnt_reg <= phase_cnt_reg + 25'h1;
					end
				end
				lds_pkg::ST_SOFT: begin
					if (phase_cnt_reg == SOFTSTART_CYC - 25'h1) begin
						state_reg     <= lds_pkg::ST_BLANK;
						phase_cnt_reg <= 25'h0;
					end else begin
						phase_cnt_reg <= phase_cnt_reg + 25'h1;
					end
				end
				lds_pkg::ST_BLANK: begin
					// counts dimming-on time only, so low duty stretches it
					if (EN_PWM_IN) begin
						if (phase_cnt_reg == BLANK_CYC - 25'h1) begin
							state_reg     <= lds_pkg::ST_RUN;
							phase_cnt_reg <= 25'h0;
						end else begin
							phase_cnt_reg <= phase_cnt_reg + 25'h1;
						end
					end
				end
				lds_pkg::ST_RUN: begin
					phase_cnt_reg <= 25'h0;
				end
				default: begin
					state_reg     <= lds_pkg::ST_OFF;
					phase_cnt_reg <= 25'h0;
				end
			endcase
		end
	end

	// ==========================================================
	// channel usage capture
	// floating sense at the end of detection marks a channel unused
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			used_reg <= 4'h0;
		end else if (seq_clear) begin
			used_reg <= 4'h0;
		end else if (state_reg == lds_pkg::ST_DETECT &&
				phase_cnt_reg == DETECT_CYC - 25'h1) begin
			used_reg <= ~CH_FLOAT_IN;
		end
	end

	// ==========================================================
	// rising-edge blanking
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			en_prev_reg <= 1'b0;
			eb_cnt_reg  <= 10'h0;
			eb_done_reg <= 1'b0;
		end else begin
			en_prev_reg <= EN_PWM_IN;
			// restart blanking after shutdown or lockout even without a fresh edge
			if (seq_clear) begin
				eb_cnt_reg  <= 10'h0;
				eb_done_reg <= 1'b0;
			end else if (EN_PWM_IN && !en_prev_reg) begin
				eb_cnt_reg  <= 10'h0;
				eb_done_reg <= 1'b0;
			end else if (EN_PWM_IN && !eb_done_reg) begin
				if (eb_cnt_reg == EB_LAST) begin
					eb_done_reg <= 1'b1;
				end else begin
					eb_cnt_reg <= eb_cnt_reg + 10'h1;
				end
			end
		end
	end

	// ==========================================================
	// fault timers
	// first high cycle after a rise is already excluded by en_prev_reg
	assign prot_on   = (state_reg == lds_pkg::ST_RUN) && !SUPPLY_LOW_IN;
	assign fault_arm = prot_on && EN_PWM_IN && en_prev_reg && eb_done_reg;
	assign open_cond = |(CH_OPEN_SENSE_IN & used_reg);

	lds_fault_timer #(
		.LIMIT (lds_pkg::OPEN_CYC)
	) u_open (
		.clk_in   (CLOCK_IN),
		.rst_n_in (RST_N_IN),
		.clear_in (seq_clear),
		.cond_in  (open_cond),
		.arm_in   (fault_arm),
		.trip_out (open_trip)
	);

	lds_fault_timer #(
		.LIMIT (lds_pkg::SHORT_CYC)
	) u_short (
		.clk_in   (CLOCK_IN),
		.rst_n_in (RST_N_IN),
		.clear_in (seq_clear),
		.cond_in  (SHORT_SENSE_IN),
		.arm_in   (fault_arm),
		.trip_out (short_trip)
	);

	// a shutdown or lockout clear always wins over a trip in the same cycle
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			open_latch_reg  <= 1'b0;
			short_latch_reg <= 1'b0;
		end else if (seq_clear) begin
			open_latch_reg  <= 1'b0;
			short_latch_reg <= 1'b0;
		end else begin
			if (open_trip) begin
				open_latch_reg <= 1'b1;
			end
			if (short_trip) begin
				short_latch_reg <= 1'b1;
			end
		end
	end

	// ==========================================================
	// pin drivers
	always_comb begin
		gate_next = 4'h0;
		if (!SUPPLY_LOW_IN && !OVER_TEMP_IN && !open_latch_reg && !short_latch_reg &&
				EN_PWM_IN && (state_reg == lds_pkg::ST_SOFT ||
				state_reg == lds_pkg::ST_BLANK || state_reg == lds_pkg::ST_RUN)) begin
			gate_next = used_reg & ~mask_reg;
		end
	end

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			CHANNEL_GATE_DRIVE_OUT        <= 4'h0;
			CONVERTER_FEEDBACK_FORCE_OUT  <= 1'b0;
			HEADROOM_FEEDBACK_CONTROL_OUT <= 1'b0;
			FAULT_N_OUT                   <= 1'b1;
		end else begin
			CHANNEL_GATE_DRIVE_OUT       <= gate_next;
			CONVERTER_FEEDBACK_FORCE_OUT <= !SUPPLY_LOW_IN &&
				state_reg == lds_pkg::ST_SOFT;
			// switching stops on over-temperature or a latched fault
			HEADROOM_FEEDBACK_CONTROL_OUT <= !SUPPLY_LOW_IN && !OVER_TEMP_IN &&
				!open_latch_reg && !short_latch_reg &&
				(state_reg == lds_pkg::ST_BLANK || state_reg == lds_pkg::ST_RUN);
			FAULT_N_OUT <= SUPPLY_LOW_IN ||
				!(OVER_TEMP_IN || open_latch_reg || short_latch_reg);
		end
	end

	// ==========================================================
	// apb slave, one wait state
	assign apb_access = PSEL_IN && PENABLE_IN;
	assign apb_take   = apb_access && PREADY_OUT;
	assign addr_ok    = (PADDR_IN == lds_pkg::STATUS_ADDR) || (PADDR_IN == lds_pkg::CTRL_ADDR);

	always_comb begin
		status_word = 32'h0;
		status_word[lds_pkg::STAT_STATE_POS +: 5] = state_reg;
		status_word[lds_pkg::STAT_USED_POS +: 4]  = used_reg;
		status_word[lds_pkg::STAT_OPEN_POS]       = open_latch_reg;
		status_word[lds_pkg::STAT_SHORT_POS]      = short_latch_reg;
		status_word[lds_pkg::STAT_THERM_POS]      = OVER_TEMP_IN;
		status_word[lds_pkg::STAT_LOCK_POS]       = SUPPLY_LOW_IN;
	end

	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			PREADY_OUT  <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT  <= 32'h0;
		end else begin
			PREADY_OUT  <= apb_access && !PREADY_OUT;
			PSLVERR_OUT <= apb_access && !PREADY_OUT && !addr_ok;
			if (apb_access && !PREADY_OUT && !PWRITE_IN) begin
				if (PADDR_IN == lds_pkg::STATUS_ADDR) begin
					PRDATA_OUT <= status_word;
				end else if (PADDR_IN == lds_pkg::CTRL_ADDR) begin
					PRDATA_OUT <= {28'h0, mask_reg};
				end else begin
					PRDATA_OUT <= 32'h0;
				end
			end
		end
	end

	// channel disable mask, applied on top of detection
	always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			mask_reg <= lds_pkg::CTRL_RESET;
		end else if (apb_take && PWRITE_IN && PADDR_IN == lds_pkg::CTRL_ADDR) begin
			mask_reg <= PWDATA_IN[lds_pkg::CTRL_MASK_POS +: 4];
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RST_N_IN);

	lockout_off_a: assert property (SUPPLY_LOW_IN |=> CHANNEL_GATE_DRIVE_OUT == 4'h0 && state_reg == lds_pkg::ST_OFF) else $error("lockout did not force off");
	shutdown_go_a: assert property ($rose(low_done) |=> state_reg == lds_pkg::ST_OFF) else $error("no shutdown after low delay");
	restart_seq_a: assert property ((state_reg == lds_pkg::ST_OFF && EN_PWM_IN && !SUPPLY_LOW_IN) |=> state_reg == lds_pkg::ST_DETECT) else $error("no restart from off");
	dim_gate_a: assert property ((state_reg == lds_pkg::ST_RUN && !EN_PWM_IN) |=> CHANNEL_GATE_DRIVE_OUT == 4'h0) else $error("gate on while dimming low");
	soft_noprot_a: assert property ((state_reg == lds_pkg::ST_SOFT) |-> !fault_arm && CONVERTER_FEEDBACK_FORCE_OUT == $past(state_reg == lds_pkg::ST_SOFT && !SUPPLY_LOW_IN)) else $error("soft start protection or force wrong");
	blank_hold_a: assert property ((state_reg == lds_pkg::ST_BLANK && !EN_PWM_IN && !seq_clear) |=> $stable(phase_cnt_reg)) else $error("blanking counted while dim low");
	edge_blank_a: assert property ($rose(EN_PWM_IN) |-> !fault_arm [*8]) else $error("fault armed right after rising edge");
	open_trip_a: assert property ($rose(open_latch_reg) |=> !FAULT_N_OUT && CHANNEL_GATE_DRIVE_OUT == 4'h0) else $error("open fault not signalled");
	short_trip_a: assert property ($rose(short_latch_reg) |=> !FAULT_N_OUT && CHANNEL_GATE_DRIVE_OUT == 4'h0) else $error("short fault not signalled");
	latch_clear_a: assert property ($fell(open_latch_reg) || $fell(short_latch_reg) |-> $past(seq_clear)) else $error("fault cleared without shutdown");
	thermal_off_a: assert property ((OVER_TEMP_IN && !SUPPLY_LOW_IN) |=> !FAULT_N_OUT && CHANNEL_GATE_DRIVE_OUT == 4'h0 && !HEADROOM_FEEDBACK_CONTROL_OUT) else $error("over-temperature not handled");
endmodule

//--- bench/lds_pwm_host.sv
// pwm host model driving the enable/dimming input of the controller
// assumes one clock shared with the controller; changes only after rising edges
`timescale 1ns/1ps
module lds_pwm_host (
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        run_in,
	input  wire logic [15:0] high_in,
	input  wire logic [15:0] low_in,
	output logic             en_out
);
	// ==========================================================
	// pwm generator
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;

	// low_in of zero gives a steady high level
	assign cnt_next = (cnt_reg + 16'h0001 >= high_in + low_in) ? 16'h0000 : cnt_reg + 16'h0001;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cnt_reg <= 16'h0000;
			en_out  <= 1'b0;
		end else if (!run_in) begin
			cnt_reg <= 16'h0000;
			en_out  <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			en_out  <= cnt_reg < high_in;
		end
	end
endmodule

//--- bench/led_driver_sequence_fault_ctrl_test.sv
// self-checking bench for the led sequencer and fault controller
// assumes lds_pkg and the pwm host model are compiled first
`timescale 1ns/1ps
module led_driver_sequence_fault_ctrl_test;
	// ==========================================================
	// signals
	logic        clk, rst_n, sup_low, ot, short_s, run;
	logic        psel, penable, pwrite, pready, pslverr;
	logic        force_fb, headroom, fault_n, en, en_d, follow;
	logic [3:0]  ch_float, ch_open, gates, m_used, m_mask;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, wd;
	logic [15:0] hi_c, lo_c;
	int          n_errors, compares, cyc_n, n, t0;

	lds_ctrl #(.DETECT_CYC(25'd20), .SOFTSTART_CYC(25'd40), .BLANK_CYC(25'd30),
		.SHDN_CYC(25'd25)) dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n), .EN_PWM_IN(en),
		.SUPPLY_LOW_IN(sup_low), .OVER_TEMP_IN(ot), .CH_FLOAT_IN(ch_float),
		.CH_OPEN_SENSE_IN(ch_open), .SHORT_SENSE_IN(short_s), .PSEL_IN(psel),
		.PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
		.PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
		.CHANNEL_GATE_DRIVE_OUT(gates), .CONVERTER_FEEDBACK_FORCE_OUT(force_fb),
		.HEADROOM_FEEDBACK_CONTROL_OUT(headroom), .FAULT_N_OUT(fault_n));

	lds_pwm_host host_u (.clk_in(clk), .rst_n_in(rst_n), .run_in(run), .high_in(hi_c),
		.low_in(lo_c), .en_out(en));

	// ==========================================================
	// clock, cycle count and gate-follow monitor
	always #4 clk = ~clk;

	always @(posedge clk) begin
		cyc_n++;
		if (follow) check("gates_follow", {28'h0, eg(en_d)}, {28'h0, gates});
		en_d = en;
	end

	// ==========================================================
	// helpers
	function automatic logic [3:0] eg(input logic e);
		return e ? (m_used & ~m_mask) : 4'h0;
	endfunction

	function automatic logic [31:0] outs();
		return {25'h0, gates, force_fb, headroom, fault_n};
	endfunction

	function automatic logic [31:0] st(input logic [4:0] s, input logic [3:0] fl);
		return {16'h0, fl, m_used, 3'h0, s};
	endfunction

	task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic check_in(input string nm, input int g, input int lo, input int hi);
		compares++;
		if (g < lo || g > hi) begin
			n_errors++;
			$display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 20) check("apb_ready", 32'h1, 32'h0);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input string nm);
		logic [31:0] d;
		logic        e;
		apb(1'b0, a, 32'h0, d, e);
		check(nm, x, d);
		check({nm, "_err"}, 32'h0, {31'h0, e});
	endtask

	task automatic wait_st(input logic [4:0] s, input int lim);
		logic [31:0] d;
		logic        e;
		int          k;
		k = 0;
		do begin
			apb(1'b0, lds_pkg::STATUS_ADDR, 32'h0, d, e);
			k++;
		end while (d[4:0] !== s && k < lim);
		check("state", {27'h0, s}, {27'h0, d[4:0]});
	endtask

	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ==========================================================
	// watchdog; whole run is well under ten thousand cycles
	initial begin
		#(8 * 60000);
		n_errors++;
		$display("BAD watchdog expected finish seen hang");
		complete_run();
	end

	// ==========================================================
	// tests
	initial begin
		logic [31:0] d;
		logic        e;
		{clk, rst_n, sup_low, ot, short_s, run, psel, penable, pwrite, follow, en_d} = '0;
		{ch_float, ch_open, m_used, m_mask, paddr, pwdata} = '0;
		{n_errors, compares, cyc_n} = '0;
		hi_c = 16'h0001;
		lo_c = 16'h0000;
		void'($urandom(90934));
		cyc(5);
		rst_n <= 1'b1;
		@(posedge clk);
		check("reset_out", 32'h1, outs());
		rd_chk(lds_pkg::STATUS_ADDR, st(lds_pkg::ST_OFF, 4'h0), "status_off");
		wd = $urandom & 32'hffff_fffe;
		m_mask = wd[3:0];
		apb(1'b1, lds_pkg::CTRL_ADDR, wd, d, e);
		rd_chk(lds_pkg::CTRL_ADDR, {28'h0, m_mask}, "ctrl");
		apb(1'b0, 12'h008, 32'h0, d, e);
		check("unmapped_rd", 32'h1, {31'h0, e});
		check("unmapped_data", 32'h0, d);
		$display("test registers done");

		ch_float <= 4'($urandom) & 4'he;
		run <= 1'b1;
		wait_st(lds_pkg::ST_DETECT, 20);
		check("gates_detect", 32'h0, {28'h0, gates});
		wait_st(lds_pkg::ST_SOFT, 40);
		check("force_soft", 32'h1, {31'h0, force_fb});
		wait_st(lds_pkg::ST_BLANK, 40);
		check("force_blank", 32'h0, {31'h0, force_fb});
		wait_st(lds_pkg::ST_RUN, 40);
		m_used = ~ch_float;
		rd_chk(lds_pkg::STATUS_ADDR, st(lds_pkg::ST_RUN, 4'h0), "status_run");
		check("run_out", {25'h0, eg(1'b1), 3'b011}, outs());
		$display("test power_up done");

		ot <= 1'b1;
		cyc(3);
		check("ot_out", 32'h0, outs());
		ot <= 1'b0;
		cyc(3);
		check("ot_back", {25'h0, eg(1'b1), 3'b011}, outs());
		run <= 1'b0;
		cyc(10);
		run <= 1'b1;
		cyc(600);
		rd_chk(lds_pkg::STATUS_ADDR, st(lds_pkg::ST_RUN, 4'h0), "status_gap");
		$display("test temp_and_gap done");

		short_s <= 1'b1;
		n = 0;
		while (fault_n !== 1'b0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		check_in("short_trip", n, lds_pkg::SHORT_CYC, lds_pkg::SHORT_CYC + 8);
		check("short_out", 32'h0, outs());
		short_s <= 1'b0;
		run <= 1'b0;
		cyc(10);
		run <= 1'b1;
		cyc(50);
		check("short_held", 32'h0, outs());
		run <= 1'b0;
		cyc(40);
		m_used = 4'h0;
		check("shdn_out", 32'h1, outs());
		rd_chk(lds_pkg::STATUS_ADDR, st(lds_pkg::ST_OFF, 4'h0), "status_shdn");
		$display("test short_fault done");

		run <= 1'b1;
		wait_st(lds_pkg::ST_RUN, 60);
		m_used = ~ch_float;
		ch_open <= 4'h1;
		run <= 1'b0;
		cyc(5);
		run <= 1'b1;
		n = 0;
		while (fault_n !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		t0 = lds_pkg::EDGE_BLANK_CYC + lds_pkg::OPEN_CYC;
		check_in("open_trip", n, t0, t0 + 15);
		check("open_out", 32'h0, outs());
		ch_open <= 4'h0;
		run <= 1'b0;
		cyc(40);
		check("open_clear", 32'h1, outs());
		$display("test open_fault done");

		lo_c <= 16'h0001;
		run <= 1'b1;
		wait_st(lds_pkg::ST_BLANK, 60);
		t0 = cyc_n;
		wait_st(lds_pkg::ST_RUN, 40);
		check_in("blank_len", cyc_n - t0, 50, 70);
		hi_c <= 16'($urandom_range(8, 1));
		lo_c <= 16'($urandom_range(8, 1));
		follow = 1'b1;
		cyc(200);
		follow = 1'b0;
		$display("test dimming done");

		lo_c <= 16'h0000;
		cyc(20);
		sup_low <= 1'b1;
		cyc(3);
		check("lock_out", 32'h1, outs());
		m_used = 4'h0;
		rd_chk(lds_pkg::STATUS_ADDR, st(lds_pkg::ST_OFF, 4'h8), "status_lock");
		sup_low <= 1'b0;
		wait_st(lds_pkg::ST_SOFT, 40);
		$display("test lockout done");
		complete_run();
	end
endmodule
